// ---- hw/asq_regs.svh ----
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 32-bit APB, one register per aligned word
// Notes: byte addresses throughout
//
// Functional notes
// - one scan per tick, conversions at most 100 or 200 ksamples/s by build option.
// - input taken from backplane bus or front panel, never both in one run.
// - two output banks of 2048 words, one filling, one held for readout.
// - banks swap at the start of every scan.
// - each sample clock tick taken between scans sends new data to the opposite bank; ticks mid-scan are dropped.
// - large buffer is 4 or 16 MB, size and segments programmable.
// - large buffer write address wraps from last location to first.
// - a filled segment sets its full flag and requests an interrupt.
// - refilling a segment still full sets the overrun flag.
// - transient mode records circularly with programmable size and counts.
// - transient trigger from front panel, backplane line or software.
// - after trigger, post-trigger count runs down and recording stops at zero.
// - captured data holds until transient enable is cleared; setting it again re-arms the capture.
// - stream bus master drives clock per conversion and frame per scan.
// - internal sample clock from 10 MHz, 11 rates 100 Hz to 200 kHz, 1-2-5.
// - any one of 8 backplane trigger lines may be the sample clock.
// - one scan address counter steps per conversion, selects entry and store slot.
// - entry bit 15 marks the last channel; later entries are ignored.
// - converter uses only bit 15 and bus phase bits 1:0 of each entry.
`ifndef ASQ_REGS_SVH
`define ASQ_REGS_SVH

`define ASQ_CTRL 16'h0000
`define ASQ_SCLK 16'h0004
`define ASQ_TRIG 16'h0008
`define ASQ_MBTOP 16'h000C
`define ASQ_SEGTOP 16'h0010
`define ASQ_FLAGS 16'h0014
`define ASQ_POST 16'h0018
`define ASQ_STAT 16'h001C
`define ASQ_TADDR 16'h0020
`define ASQ_SCAN_BASE 16'h2000
`define ASQ_PP_BASE 16'h4000
`define ASQ_WIN_BYTES 16'h2000

`define ASQ_C_RUN 0
`define ASQ_C_SRC 1
`define ASQ_C_MULTI 2
`define ASQ_C_TRANS 3
`define ASQ_C_SWTRG 4
`define ASQ_C_DIGI 5
`define ASQ_T_FP 0
`define ASQ_T_LINE 1
`define ASQ_EOL_BIT 15

`define ASQ_MBTOP_RST 23'h7FFFFF
`define ASQ_SEGTOP_RST 23'h0FFFFF
`define ASQ_POST_RST 23'h000400

`define ASQ_CLK_NS 50
`define ASQ_CONV_NS_FAST 5000
`define ASQ_CONV_NS_SLOW 10000
`define ASQ_CONV_CYC_FAST ((`ASQ_CONV_NS_FAST + `ASQ_CLK_NS - 1) / `ASQ_CLK_NS)
`define ASQ_CONV_CYC_SLOW ((`ASQ_CONV_NS_SLOW + `ASQ_CLK_NS - 1) / `ASQ_CLK_NS)
`define ASQ_BASE_DIV_100HZ 100000

`endif

// ---- hw/asq_pkg.sv ----
// Purpose: types shared by the scan sequencer files
// Assumes: nothing
// Notes: clock generator and top state live in one packed struct each, beside the top's gap counter
package asq_pkg;

  typedef enum logic [2:0] {ASQ_IDLE, ASQ_WAIT, ASQ_FETCH, ASQ_CONV, ASQ_BUSY} asq_seq_e;

  typedef struct packed {
    logic start;
    logic [1:0] phase;
    logic srcFront;
  } asq_conv_s;

  typedef struct packed {
    logic [10:0] addr;
    logic frame;
    logic step;
    logic last;
  } asq_scan_s;

  typedef struct packed {
    logic clk;
    logic frame;
    logic [15:0] data;
  } asq_digi_s;

  typedef struct packed {
    logic we;
    logic [22:0] addr;
    logic [15:0] data;
  } asq_mb_s;

  typedef struct packed {
    logic b1;
    logic b2;
    logic b3;
    logic [7:0] l1;
    logic [7:0] l2;
    logic lD;
    logic [16:0] cnt;
    logic tick;
  } asq_gen_s;

  typedef struct packed {
    asq_seq_e seq;
    logic wrBank;
    logic [7:0] convCnt;
    asq_conv_s conv;
    asq_scan_s scan;
    asq_digi_s digi;
    asq_mb_s mb;
    logic [22:0] mbPtr;
    logic [22:0] segCnt;
    logic [22:0] postLeft;
    logic [22:0] trigAddr;
    logic [2:0] segIdx;
    logic [7:0] full;
    logic ovr;
    logic capDone;
    logic trigHit;
    logic irq;
    logic transEnD;
    logic fpS1;
    logic fpS2;
    logic fpS3;
    logic lineD;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic [5:0] ctrl;
    logic [7:0] sclk;
    logic [4:0] trig;
    logic [22:0] mbTop;
    logic [22:0] segTop;
    logic [22:0] post;
  } asq_top_s;

endpackage : asq_pkg

// ---- hw/asq_ram.sv ----
// Purpose: simple dual-port word memory with registered read data
// Assumes: one write and one read port on clk_sys
// Notes: read data appear one cycle after the address
`timescale 1ns/100ps
module asq_ram #(
  parameter int DW = 16,
  parameter int AW = 11
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic we,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : asq_ram

// ---- hw/asq_clkgen.sv ----
// Purpose: sample clock tick from divided backplane clock or a trigger line
// Assumes: backplane clock and lines are asynchronous pins
// Notes: tick is a one-cycle pulse on clk_sys
`timescale 1ns/100ps
`include "asq_regs.svh"
module asq_clkgen #(
  parameter int BASE_DIV = `ASQ_BASE_DIV_100HZ
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic bpClk,
  input wire logic [7:0] trigLines,
  input wire logic [3:0] rateSel,
  input wire logic useLine,
  input wire logic [2:0] lineSel,
  output logic tick,
  output logic [7:0] lineSync
);
  asq_pkg::asq_gen_s s;
  asq_pkg::asq_gen_s n;

  function automatic logic [16:0] divOf(input logic [3:0] r);
    case (r)
      4'h0: divOf = 17'(BASE_DIV);
      4'h1: divOf = 17'(BASE_DIV / 2);
      4'h2: divOf = 17'(BASE_DIV / 5);
      4'h3: divOf = 17'(BASE_DIV / 10);
      4'h4: divOf = 17'(BASE_DIV / 20);
      4'h5: divOf = 17'(BASE_DIV / 50);
      4'h6: divOf = 17'(BASE_DIV / 100);
      4'h7: divOf = 17'(BASE_DIV / 200);
      4'h8: divOf = 17'(BASE_DIV / 500);
      4'h9: divOf = 17'(BASE_DIV / 1000);
      default: divOf = 17'(BASE_DIV / 2000);
    endcase
  endfunction : divOf

  always_comb begin
    n = s;
    n.tick = 1'b0;
    n.b1 = bpClk;
    n.b2 = s.b1;
    n.b3 = s.b2;
    n.l1 = trigLines;
    n.l2 = s.l1;
    n.lD = s.l2[lineSel];
    if (useLine) begin
      n.tick = s.l2[lineSel] & ~s.lD;
    end else if (s.b2 && !s.b3) begin
      if (s.cnt == 17'h0) begin
        n.tick = 1'b1;
        n.cnt = divOf(rateSel) - 17'h1;
      end else begin
        n.cnt = s.cnt - 17'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
  assign lineSync = s.l2;
endmodule : asq_clkgen

// ---- hw/asq_top.sv ----
// Purpose: scan list sequencing, bank buffering and large-buffer addressing
// Assumes: converter logic on clk_sys answers each start with adcDone
// Notes: APB answers every access with one wait state
`timescale 1ns/100ps
`include "asq_regs.svh"
module asq_top #(
  parameter bit FAST_CONV = 1'b1,
  parameter int MB_AW = 23,
  parameter int BASE_DIV = `ASQ_BASE_DIV_100HZ
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bpClk,
  input wire logic [7:0] trigLines,
  input wire logic fpTrigIn,
  input wire logic adcDone,
  input wire logic [15:0] adcData,
  output asq_pkg::asq_conv_s conv,
  output asq_pkg::asq_scan_s scan,
  output asq_pkg::asq_digi_s digi,
  output asq_pkg::asq_mb_s mb,
  output logic segIrq
);
  localparam logic [7:0] CONV_CYC =
    FAST_CONV ? 8'(`ASQ_CONV_CYC_FAST) : 8'(`ASQ_CONV_CYC_SLOW);
  localparam int CONV_MIN = FAST_CONV ? `ASQ_CONV_CYC_FAST : `ASQ_CONV_CYC_SLOW;
  localparam logic [22:0] MB_MASK = 23'((64'h1 << MB_AW) - 64'h1);

  asq_pkg::asq_top_s s;
  asq_pkg::asq_top_s n;
  logic tick;
  logic [7:0] lineSync;
  logic [15:0] scanRd;
  logic [15:0] ppRd;
  logic inScan;
  logic inPp;
  logic wrDone;
  logic ppWe;
  logic mbGo;
  logic trigEv;
  logic rearm;
  logic [11:0] ppWrAddr;
  logic [11:0] ppRdAddr;
  logic [7:0] gap;

  assign inScan = paddr >= `ASQ_SCAN_BASE && paddr < (`ASQ_SCAN_BASE + `ASQ_WIN_BYTES);
  assign inPp = paddr >= `ASQ_PP_BASE && paddr < (`ASQ_PP_BASE + `ASQ_WIN_BYTES);
  assign wrDone = psel && penable && s.ready && pwrite;
  assign ppWe = s.seq == asq_pkg::ASQ_BUSY && adcDone;
  // fill one bank, host reads the other
  assign ppWrAddr = {s.wrBank, s.scan.addr};
  assign ppRdAddr = {~s.wrBank, paddr[12:2]};
  // no writes over a held capture
  assign mbGo = ppWe && s.ctrl[`ASQ_C_MULTI] && !(s.ctrl[`ASQ_C_TRANS] && s.capDone);
  assign rearm = s.ctrl[`ASQ_C_TRANS] && !s.transEnD;
  assign trigEv = s.ctrl[`ASQ_C_SWTRG]
    || (s.trig[`ASQ_T_FP] && s.fpS3 && !s.fpS2)
    || (s.trig[`ASQ_T_LINE] && lineSync[s.trig[4:2]] && !s.lineD);

  asq_clkgen #(
    .BASE_DIV(BASE_DIV)
  ) u_clkgen (
    .clk_sys(clk_sys),
    .reset(reset),
    .bpClk(bpClk),
    .trigLines(trigLines),
    .rateSel(s.sclk[3:0]),
    .useLine(s.sclk[4]),
    .lineSel(s.sclk[7:5]),
    .tick(tick),
    .lineSync(lineSync)
  );

  // list loaded by software over the bus
  asq_ram #(
    .DW(16),
    .AW(11)
  ) u_scanram (
    .clk_sys(clk_sys),
    .reset(reset),
    .we(wrDone && inScan),
    .wrAddr(paddr[12:2]),
    .wrData(pwdata[15:0]),
    .rdAddr(s.scan.addr),
    .rdData(scanRd)
  );

  asq_ram #(
    .DW(16),
    .AW(12)
  ) u_pingpong (
    .clk_sys(clk_sys),
    .reset(reset),
    .we(ppWe),
    .wrAddr(ppWrAddr),
    .wrData(adcData),
    .rdAddr(ppRdAddr),
    .rdData(ppRd)
  );

  always_comb begin
    n = s;
    n.conv.start = 1'b0;
    n.scan.frame = 1'b0;
    n.scan.step = 1'b0;
    n.digi.clk = 1'b0;
    n.digi.frame = 1'b0;
    n.mb.we = 1'b0;
    n.ctrl[`ASQ_C_SWTRG] = 1'b0;
    n.fpS1 = fpTrigIn;
    n.fpS2 = s.fpS1;
    n.fpS3 = s.fpS2;
    n.lineD = lineSync[s.trig[4:2]];
    n.transEnD = s.ctrl[`ASQ_C_TRANS];
    if (s.convCnt != 8'h00) begin
      n.convCnt = s.convCnt - 8'h01;
    end
    // bus: answer one cycle into the access phase
    n.ready = 1'b0;
    if (psel && penable && !s.ready) begin
      n.ready = 1'b1;
      n.slverr = 1'b0;
      n.rdata = '0;
      if (paddr == `ASQ_CTRL) begin
        n.rdata = {26'h0, s.ctrl};
      end else if (paddr == `ASQ_SCLK) begin
        n.rdata = {24'h0, s.sclk};
      end else if (paddr == `ASQ_TRIG) begin
        n.rdata = {27'h0, s.trig};
      end else if (paddr == `ASQ_MBTOP) begin
        n.rdata = {9'h0, s.mbTop};
      end else if (paddr == `ASQ_SEGTOP) begin
        n.rdata = {9'h0, s.segTop};
      end else if (paddr == `ASQ_FLAGS) begin
        n.rdata = {21'h0, s.trigHit, s.capDone, s.ovr, s.full};
      end else if (paddr == `ASQ_POST) begin
        n.rdata = {9'h0, s.post};
      end else if (paddr == `ASQ_STAT) begin
        n.rdata = {15'h0, s.wrBank, 5'h0, s.scan.addr};
      end else if (paddr == `ASQ_TADDR) begin
        n.rdata = {9'h0, s.trigAddr};
      end else if (inScan) begin
        // list is write-only: its read port belongs to the sequencer
        n.rdata = '0;
      end else if (inPp) begin
        n.rdata = {16'h0, ppRd};
      end else begin
        n.slverr = 1'b1;
      end
    end
    if (wrDone) begin
      if (paddr == `ASQ_CTRL) begin
        n.ctrl = pwdata[5:0];
      end else if (paddr == `ASQ_SCLK) begin
        n.sclk = pwdata[7:0];
      end else if (paddr == `ASQ_TRIG) begin
        n.trig = pwdata[4:0];
      end else if (paddr == `ASQ_MBTOP) begin
        // used size within the fitted memory
        n.mbTop = pwdata[22:0] & MB_MASK;
      end else if (paddr == `ASQ_SEGTOP) begin
        n.segTop = pwdata[22:0] & MB_MASK;
      end else if (paddr == `ASQ_FLAGS) begin
        n.full = s.full & ~pwdata[7:0];
        n.ovr = s.ovr & ~pwdata[8];
      end else if (paddr == `ASQ_POST) begin
        n.post = pwdata[22:0];
      end
    end
    case (s.seq)
      asq_pkg::ASQ_IDLE: begin
        if (s.ctrl[`ASQ_C_RUN]) begin
          // source fixed for the whole run
          n.conv.srcFront = s.ctrl[`ASQ_C_SRC];
          n.seq = asq_pkg::ASQ_WAIT;
        end
      end
      asq_pkg::ASQ_WAIT: begin
        if (!s.ctrl[`ASQ_C_RUN]) begin
          n.seq = asq_pkg::ASQ_IDLE;
        end else if (tick) begin
          n.wrBank = ~s.wrBank;
          n.scan.addr = 11'h000;
          n.scan.frame = 1'b1;
          n.digi.frame = s.ctrl[`ASQ_C_DIGI];
          n.seq = asq_pkg::ASQ_FETCH;
        end
      end
      asq_pkg::ASQ_FETCH: begin
        n.seq = asq_pkg::ASQ_CONV;
      end
      asq_pkg::ASQ_CONV: begin
        if (s.convCnt == 8'h00) begin
          n.convCnt = CONV_CYC - 8'h01;
          n.conv.start = 1'b1;
          n.conv.phase = scanRd[1:0];
          n.scan.last = scanRd[`ASQ_EOL_BIT];
          n.scan.step = 1'b1;
          n.seq = asq_pkg::ASQ_BUSY;
        end
      end
      asq_pkg::ASQ_BUSY: begin
        if (adcDone) begin
          n.digi.clk = s.ctrl[`ASQ_C_DIGI];
          n.digi.data = adcData;
          if (s.scan.last) begin
            // back to zero, wait next tick
            n.scan.addr = 11'h000;
            n.seq = asq_pkg::ASQ_WAIT;
          end else begin
            n.scan.addr = s.scan.addr + 11'h001;
            n.seq = asq_pkg::ASQ_FETCH;
          end
        end
      end
      default: begin
        n.seq = asq_pkg::ASQ_IDLE;
      end
    endcase
    if (mbGo) begin
      n.mb.we = 1'b1;
      n.mb.addr = s.mbPtr;
      n.mb.data = adcData;
      if (!s.ctrl[`ASQ_C_TRANS]) begin
        if (s.segCnt == 23'h0 && s.full[s.segIdx]) begin
          n.ovr = 1'b1;
        end
        if (s.segCnt == s.segTop) begin
          n.full[s.segIdx] = 1'b1;
          n.segCnt = 23'h0;
          n.segIdx = s.segIdx + 3'h1;
        end else begin
          n.segCnt = s.segCnt + 23'h1;
        end
      end
      if (s.mbPtr == s.mbTop) begin
        n.mbPtr = 23'h0;
        n.segCnt = 23'h0;
        n.segIdx = 3'h0;
      end else begin
        n.mbPtr = s.mbPtr + 23'h1;
      end
      if (s.ctrl[`ASQ_C_TRANS] && s.trigHit) begin
        n.postLeft = s.postLeft - 23'h1;
        if (s.postLeft == 23'h1) begin
          n.capDone = 1'b1;
        end
      end
    end
    if (rearm) begin
      n.capDone = 1'b0;
      n.trigHit = 1'b0;
      n.mbPtr = 23'h0;
    end else if (s.ctrl[`ASQ_C_TRANS] && trigEv && !s.trigHit) begin
      n.trigHit = 1'b1;
      n.trigAddr = s.mbPtr;
      n.postLeft = s.post;
      if (s.post == 23'h0) begin
        n.capDone = 1'b1;
      end
    end
    n.irq = |n.full;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.mbTop <= `ASQ_MBTOP_RST;
      s.segTop <= `ASQ_SEGTOP_RST;
      s.post <= `ASQ_POST_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slverr;
  assign conv = s.conv;
  assign scan = s.scan;
  assign digi = s.digi;
  assign mb = s.mb;
  assign segIrq = s.irq;

  // cycles since the last conversion start, saturating
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gap <= 8'hFF;
    end else if (s.conv.start) begin
      gap <= 8'h01;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end

  a_conv_spacing: assert property (@(posedge clk_sys) disable iff (reset)
    s.conv.start |-> gap >= CONV_MIN) else $error("conversions too close");

  a_source_held: assert property (@(posedge clk_sys) disable iff (reset)
    (s.seq != asq_pkg::ASQ_IDLE && $past(s.seq) != asq_pkg::ASQ_IDLE)
    |-> $stable(s.conv.srcFront)) else $error("source changed mid run");

  a_bank_swap: assert property (@(posedge clk_sys) disable iff (reset)
    (s.seq == asq_pkg::ASQ_WAIT && tick && s.ctrl[`ASQ_C_RUN])
    |=> (s.wrBank != $past(s.wrBank)) && s.scan.frame) else $error("no bank swap");

  a_bank_split: assert property (@(posedge clk_sys) disable iff (reset)
    ppWe |-> $stable(s.wrBank) && ppWrAddr[11] != ppRdAddr[11])
    else $error("write hits readable bank");

  a_addr_step: assert property (@(posedge clk_sys) disable iff (reset)
    (ppWe && !s.scan.last) |=> s.scan.addr == $past(s.scan.addr) + 11'h001
    ##1 s.seq == asq_pkg::ASQ_CONV) else $error("scan address did not step");

  a_list_end: assert property (@(posedge clk_sys) disable iff (reset)
    (ppWe && s.scan.last) |=> s.scan.addr == 11'h000 && s.seq == asq_pkg::ASQ_WAIT)
    else $error("list end not handled");

  a_mb_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    (mbGo && s.mbPtr == s.mbTop) |=> s.mbPtr == 23'h0) else $error("no buffer wrap");

  a_seg_full: assert property (@(posedge clk_sys) disable iff (reset)
    (mbGo && !s.ctrl[`ASQ_C_TRANS] && s.segCnt == s.segTop)
    |=> s.full[$past(s.segIdx)] && s.irq) else $error("segment full missed");

  a_capture_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (s.capDone && s.ctrl[`ASQ_C_TRANS] && s.transEnD) |=> !s.mb.we && $stable(s.mbPtr))
    else $error("capture overwritten");

  a_digi_frame: assert property (@(posedge clk_sys) disable iff (reset)
    s.digi.frame |-> s.scan.frame && $past(s.ctrl[`ASQ_C_DIGI]))
    else $error("stream frame without scan start");
endmodule : asq_top

// ---- testbench/asq_adc_model.sv ----
// Purpose: converter stand-in answering each conversion start
// Assumes: start is a one-cycle pulse on clk_sys
// Notes: result lines toggle while no result is offered
`timescale 1ns/100ps
module asq_adc_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire asq_pkg::asq_conv_s conv,
  input wire logic slow,
  output logic adcDone,
  output logic [15:0] adcData
);
  logic [7:0] cnt;
  logic busy;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      adcDone <= 1'b0;
      adcData <= 16'h0000;
      busy <= 1'b0;
      cnt <= 8'h00;
    end else begin
      adcDone <= 1'b0;
      // stale data never looks valid
      adcData <= ~adcData;
      if (conv.start) begin
        busy <= 1'b1;
        cnt <= slow ? 8'h96 : 8'h02;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        adcDone <= 1'b1;
        adcData <= 16'($urandom);
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule : asq_adc_model

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for the scan sequencer
// Assumes: sample ticks come from backplane trigger line 3
// Notes: large buffer cut to 12 words in 3 segments to force wrap
`timescale 1ns/100ps
`include "asq_regs.svh"
module tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fpTrigIn = 1'b1;
  logic bpClk = 1'b0;
  logic slow = 1'b0;
  logic err;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] rd;
  logic [7:0] trigLines = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, adcDone, segIrq;
  logic [15:0] adcData, lastData;
  asq_pkg::asq_conv_s conv;
  asq_pkg::asq_scan_s scan;
  asq_pkg::asq_digi_s digi;
  asq_pkg::asq_mb_s mb;
  int fails = 0;
  int checks = 0;
  int idx, dn, weScan;
  int frames = 0;
  int ptr = 0;
  logic [15:0] list [0:8];
  logic [15:0] cur [0:7];
  logic [15:0] prev [0:7];
  logic [15:0] q [$];
  logic [15:0] ra [4] = '{`ASQ_CTRL, `ASQ_MBTOP, `ASQ_SEGTOP, `ASQ_POST};
  logic [31:0] rv [4] = '{32'h00000000, 32'h007FFFFF, 32'h000FFFFF, 32'h00000400};

  always #25 clk_sys = ~clk_sys;
  always #50 bpClk = ~bpClk;

  asq_top #(.BASE_DIV(2000)) u_dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bpClk, .trigLines, .fpTrigIn, .adcDone,
    .adcData, .conv, .scan, .digi, .mb, .segIrq);
  asq_adc_model u_adc (.clk_sys, .reset, .conv, .slow, .adcDone, .adcData);

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // answer taken at the rising edge that sees pready high; watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse();
    @(posedge clk_sys);
    trigLines[3] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    trigLines[3] <= 1'b0;
  endtask : pulse

  // second tick lands mid-scan and must be dropped
  task automatic run_scan();
    int k;
    k = 0;
    pulse();
    repeat (300) @(posedge clk_sys);
    pulse();
    while (dn < 8 && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (10) @(posedge clk_sys);
  endtask : run_scan

  always @(posedge clk_sys) begin
    if (!reset) begin
      if (scan.frame) begin
        frames++;
        idx = 0;
        dn = 0;
        weScan = 0;
        prev = cur;
        chk("stream frame", 1, 32'(digi.frame));
      end
      if (conv.start) begin
        chk("phase", 32'(list[idx][1:0]), 32'(conv.phase));
        chk("scan addr", idx, 32'(scan.addr));
        chk("last", 32'(list[idx][15]), 32'(scan.last));
        chk("step", 1, 32'(scan.step));
        chk("source", 1, 32'(conv.srcFront));
        idx++;
      end
      if (adcDone) begin
        cur[dn] = adcData;
        q.push_back(adcData);
        lastData = adcData;
        dn++;
      end
      if (digi.clk) chk("stream", 32'(q.pop_front()), 32'(digi.data));
      if (mb.we) begin
        chk("mb addr", ptr, 32'(mb.addr));
        chk("mb data", 32'(lastData), 32'(mb.data));
        ptr = (ptr == 11) ? 0 : ptr + 1;
        weScan++;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done();
  end

  initial begin
    void'($urandom(75));
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h00000000);
      chk("reset value", rv[i], rd);
    end
    apb(1'b0, 16'h0100, 32'h00000000);
    chk("unmapped", 32'h00000001, {31'h00000000, err});
    // end mark at entry 7, bits 14:12 clear, random channel bits, entry 8 beyond the end
    for (int i = 0; i < 9; i++) begin
      list[i] = {i >= 7, 3'h0, 10'($urandom), 2'(i)};
      apb(1'b1, `ASQ_SCAN_BASE + 16'(4 * i), {16'h0000, list[i]});
    end
    apb(1'b1, `ASQ_MBTOP, 32'h0000000B);
    apb(1'b1, `ASQ_SEGTOP, 32'h00000003);
    apb(1'b1, `ASQ_SCLK, 32'h00000070);
    apb(1'b1, `ASQ_CTRL, 32'h00000027);
    run_scan();
    slow <= 1'b1;
    run_scan();
    chk("frames", 2, frames);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, `ASQ_PP_BASE + 16'(4 * i), 32'h00000000);
      chk("bank word", 32'(prev[i]), rd);
    end
    apb(1'b0, `ASQ_STAT, 32'h00000000);
    chk("write bank", 32'(frames % 2), {31'h00000000, rd[16]});
    apb(1'b0, `ASQ_FLAGS, 32'h00000000);
    chk("flags", 32'h00000107, rd);
    chk("irq", 32'h00000001, {31'h00000000, segIrq});
    apb(1'b1, `ASQ_FLAGS, 32'h000001FF);
    @(negedge clk_sys);
    chk("irq clear", 32'h00000000, {31'h00000000, segIrq});
    apb(1'b1, `ASQ_POST, 32'h00000005);
    slow <= 1'b0;
    apb(1'b1, `ASQ_CTRL, 32'h0000002F);
    ptr = 0;
    run_scan();
    chk("pre writes", 8, weScan);
    apb(1'b1, `ASQ_CTRL, 32'h0000003F);
    apb(1'b0, `ASQ_TADDR, 32'h00000000);
    chk("trig addr", 32'h00000008, rd);
    run_scan();
    chk("post writes", 5, weScan);
    apb(1'b0, `ASQ_FLAGS, 32'h00000000);
    chk("capture flags", 32'h00000600, rd);
    run_scan();
    chk("held", 0, weScan);
    apb(1'b1, `ASQ_CTRL, 32'h00000027);
    apb(1'b1, `ASQ_CTRL, 32'h0000002F);
    apb(1'b0, `ASQ_FLAGS, 32'h00000000);
    chk("rearm flags", 32'h00000000, rd);
    apb(1'b1, `ASQ_TRIG, 32'h00000001);
    fpTrigIn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    fpTrigIn <= 1'b1;
    apb(1'b0, `ASQ_FLAGS, 32'h00000000);
    chk("front trigger", 32'h00000400, rd);
    apb(1'b1, `ASQ_CTRL, 32'h00000027);
    apb(1'b1, `ASQ_CTRL, 32'h0000002F);
    apb(1'b1, `ASQ_TRIG, 32'h0000000E);
    ptr = 0;
    pulse();
    apb(1'b0, `ASQ_FLAGS, 32'h00000000);
    chk("line trigger", 32'h00000400, rd);
    test_done();
  end
endmodule : tb
